// [rtl/pd_ctrl_pkg.sv]
package pd_ctrl_pkg;

    // Register byte offsets on the APB
    localparam logic [11:0] SYSCTL_OFS = 12'h000;
    localparam logic [11:0] PDSTAT_OFS = 12'h004;

    // Control register field positions
    localparam int HW_STANDBY_PIN_SEL_BIT = 7;
    localparam int SETTLE_HI = 6;
    localparam int SETTLE_LO = 4;
    localparam int XRST_BIT = 3;
    localparam int NMI_EDGE_BIT = 2;
    localparam int HIE_BIT = 1;
    localparam int RAM_EN_BIT = 0;

    // Reset value of the control register and its writable bits
    localparam logic [7:0] SYSCTL_RST = 8'h09;
    localparam logic [7:0] SYSCTL_WMASK = 8'hF7;

    // Settling field codes
    localparam logic [2:0] SETTLE_8K = 3'h0;
    localparam logic [2:0] SETTLE_16K = 3'h1;
    localparam logic [2:0] SETTLE_32K = 3'h2;
    localparam logic [2:0] SETTLE_64K = 3'h3;
    localparam logic [2:0] SETTLE_128K = 3'h4;
    localparam logic [2:0] SETTLE_1K = 3'h5;

    // Settling counter width and the short wait (below the parameter limit)
    localparam int SETTLE_W = 18;
    localparam logic [SETTLE_W-1:0] SETTLE_1K_STATES = 18'h00400;

    // Pin vector layout: nmi, chip clear, hw standby, 8 ext ints, 16 keys
    localparam int PIN_W = 27;
    localparam int PIN_NMI = 0;
    localparam int PIN_CLR = 1;
    localparam int PIN_HWS = 2;
    localparam int PIN_EXT = 3;
    localparam int PIN_KEY = 11;

    // Operating modes
    typedef enum logic [2:0] {
        ST_RUN,
        ST_SLEEP,
        ST_SW_HW_STANDBY_PIN,
        ST_SETTLE,
        ST_CLEAR,
        ST_HW_HW_STANDBY_PIN
    } pd_state_e;

    // Control outputs toward the rest of the chip
    typedef struct packed {
        logic cpu_halt;
        logic cpu_reg_reset;
        logic periph_clk_en;
        logic periph_reset;
        logic osc_en;
        logic sys_clk_en;
        logic port_hold;
        logic port_hiz;
        logic chip_reset;
    } pd_ctl_s;

    localparam pd_ctl_s CTL_RST = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

endpackage

// [rtl/power_down_mode_controller.sv]
`timescale 1ns/1ps

module power_down_mode_controller
    import pd_ctrl_pkg::*;
#(
    parameter bit FLASH_VARIANT = 1'b1,
    parameter logic [SETTLE_W-1:0] SETTLE_8K_STATES = 18'h02000,
    parameter logic [SETTLE_W-1:0] SETTLE_16K_STATES = 18'h04000,
    parameter logic [SETTLE_W-1:0] SETTLE_32K_STATES = 18'h08000,
    parameter logic [SETTLE_W-1:0] SETTLE_64K_STATES = 18'h10000,
    parameter logic [SETTLE_W-1:0] SETTLE_128K_STATES = 18'h20000
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // CPU and interrupt logic, same clock
    input wire logic i_sleep_exec,
    input wire logic i_int_mask,
    input wire logic i_int_req,
    input wire logic [7:0] i_ext_int_enable_bits,
    // External pins, asynchronous
    input wire logic i_nmi_n,
    input wire logic i_chip_clear_pin_n,
    input wire logic i_hw_standby_pin_n,
    input wire logic [7:0] i_ext_int_pins_n,
    input wire logic [15:0] i_key_wake_inputs_n,
    // Mode controls toward the chip
    output pd_ctl_s o_ctl,
    output logic o_wake_int,
    output logic o_reset_exc,
    output logic o_onchip_ram_enable,
    output logic o_nmi_edge_select
);
    // Two-stage synchronisers on every pin
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] sync1_q;
    logic [PIN_W-1:0] sync2_q;
    assign pin_raw = {i_key_wake_inputs_n, i_ext_int_pins_n, i_hw_standby_pin_n,
                      i_chip_clear_pin_n, i_nmi_n};
    generate
        for (genvar gi = 0; gi < PIN_W; gi++)
        begin : g_sync
            // Pins idle high, so the chain resets high
            always_ff @(posedge i_clk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                begin
                    sync1_q[gi] <= 1'b1;
                    sync2_q[gi] <= 1'b1;
                end
                else
                begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate
    // Synchronised pin levels
    wire nmi_lvl = sync2_q[PIN_NMI];
    wire clr_low = !sync2_q[PIN_CLR];
    wire hws_low = !sync2_q[PIN_HWS];
    wire [7:0] ext_low = ~sync2_q[PIN_EXT +: 8];
    wire key_any_low = !(&sync2_q[PIN_KEY +: 16]);
    // Control register and state
    logic [7:0] sysctl_q;
    logic [7:0] sysctl_d;
    pd_state_e state_q;
    pd_state_e state_d;
    logic [SETTLE_W-1:0] settle_q;
    logic [SETTLE_W-1:0] settle_d;
    logic nmi_prev_q;
    logic mask_at_sleep_q;
    logic wake_src_ext_q;
    // NMI edge follows the programmed edge select
    wire nmi_rise = nmi_lvl && !nmi_prev_q;
    wire nmi_fall = !nmi_lvl && nmi_prev_q;
    wire nmi_edge = sysctl_q[NMI_EDGE_BIT] ? nmi_rise : nmi_fall;
    // Standby wake sources; ext 6 merges the key inputs
    wire irq6_low = ext_low[6] || key_any_low;
    wire [3:0] hw_standby_pin_src = {irq6_low, ext_low[2:0]};
    wire [3:0] hw_standby_pin_en = {i_ext_int_enable_bits[6], i_ext_int_enable_bits[2:0]};
    // Ext 3, 4, 5 and 7 are not looked at here; software disables them first
    wire hw_standby_pin_wake = nmi_edge || (|(hw_standby_pin_src & hw_standby_pin_en));
    // Sleep wake: masked requests count only via NMI
    wire sleep_wake = nmi_edge || (i_int_req && !mask_at_sleep_q);
    // Settling code to wait length
    wire [2:0] settle_code = sysctl_q[SETTLE_HI:SETTLE_LO];
    logic [SETTLE_W-1:0] settle_len;
    always_comb
    begin
        unique case (settle_code)
            SETTLE_8K: settle_len = SETTLE_8K_STATES;
            SETTLE_16K: settle_len = SETTLE_16K_STATES;
            SETTLE_32K: settle_len = SETTLE_32K_STATES;
            SETTLE_64K: settle_len = SETTLE_64K_STATES;
            SETTLE_128K: settle_len = SETTLE_128K_STATES;
            // Short wait only on the flash variant; unused codes take the longest
            SETTLE_1K: settle_len = FLASH_VARIANT ? SETTLE_1K_STATES : SETTLE_128K_STATES;
            default: settle_len = SETTLE_128K_STATES;
        endcase
    end
    // Mode sequencing, hw standby first, then chip clear, then interrupts
    always_comb
    begin
        state_d = state_q;
        settle_d = settle_q;
        if (hws_low)
            state_d = ST_HW_HW_STANDBY_PIN;
        else
        begin
            unique case (state_q)
                ST_RUN:
                begin
                    if (clr_low)
                        state_d = ST_CLEAR;
                    else if (i_sleep_exec)
                        state_d = sysctl_q[HW_STANDBY_PIN_SEL_BIT] ? ST_SW_HW_STANDBY_PIN : ST_SLEEP;
                end
                ST_SLEEP:
                begin
                    if (clr_low)
                        state_d = ST_CLEAR;
                    else if (sleep_wake)
                        state_d = ST_RUN;
                end
                ST_SW_HW_STANDBY_PIN:
                begin
                    if (clr_low)
                        state_d = ST_CLEAR;
                    else if (hw_standby_pin_wake)
                    begin
                        state_d = ST_SETTLE;
                        settle_d = settle_len - 18'h00001;
                    end
                end
                ST_SETTLE:
                begin
                    if (clr_low)
                        state_d = ST_CLEAR;
                    else if (settle_q == '0)
                        state_d = ST_RUN;
                    else
                        settle_d = settle_q - 18'h00001;
                end
                // Oscillator runs here; reset starts when clear rises
                ST_CLEAR:
                begin
                    if (!clr_low)
                        state_d = ST_RUN;
                end
                // Leaving hw standby goes through the clear state
                ST_HW_HW_STANDBY_PIN: state_d = ST_CLEAR;
            endcase
        end
    end
    // Control outputs decoded from the next state, so they leave a flop
    pd_ctl_s ctl_d;
    always_comb
    begin
        ctl_d = '0;
        unique case (state_d)
            ST_RUN:
            begin
                ctl_d.periph_clk_en = 1'b1;
                ctl_d.osc_en = 1'b1;
                ctl_d.sys_clk_en = 1'b1;
            end
            ST_SLEEP:
            begin
                ctl_d.cpu_halt = 1'b1;
                ctl_d.periph_clk_en = 1'b1;
                ctl_d.osc_en = 1'b1;
                ctl_d.sys_clk_en = 1'b1;
            end
            ST_SW_HW_STANDBY_PIN, ST_SETTLE:
            begin
                ctl_d.cpu_halt = 1'b1;
                ctl_d.periph_reset = 1'b1;
                ctl_d.port_hold = 1'b1;
                ctl_d.osc_en = (state_d == ST_SETTLE);
            end
            ST_CLEAR:
            begin
                ctl_d.cpu_halt = 1'b1;
                ctl_d.cpu_reg_reset = 1'b1;
                ctl_d.periph_reset = 1'b1;
                ctl_d.osc_en = 1'b1;
                ctl_d.sys_clk_en = 1'b1;
                ctl_d.chip_reset = 1'b1;
            end
            ST_HW_HW_STANDBY_PIN:
            begin
                ctl_d.cpu_halt = 1'b1;
                ctl_d.cpu_reg_reset = 1'b1;
                ctl_d.periph_reset = 1'b1;
                ctl_d.port_hiz = 1'b1;
                ctl_d.chip_reset = 1'b1;
            end
        endcase
    end
    // One-cycle starts of interrupt and reset handling
    wire wake_int_d = (state_d == ST_RUN) && (state_q == ST_SLEEP || state_q == ST_SETTLE);
    wire reset_exc_d = (state_d == ST_RUN) && (state_q == ST_CLEAR);
    // APB decode; one wait-free access, answer registered in setup
    wire apb_setup = i_psel && !i_penable;
    wire hit_ctl = (i_paddr == SYSCTL_OFS);
    wire hit_stat = (i_paddr == PDSTAT_OFS);
    wire apb_wr = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;
    wire ctl_wr = apb_wr && hit_ctl;
    wire [31:0] stat_word = {8'h00, wake_src_ext_q, mask_at_sleep_q, settle_q,
                             1'b0, 3'(state_q)};
    wire [31:0] rd_mux = hit_ctl ? {24'h000000, sysctl_q} : (hit_stat ? stat_word : 32'h0);
    wire wr_to_stat = i_pwrite && hit_stat;
    // Control register: writes keep read-only bits; hw standby reinitialises it
    always_comb
    begin
        sysctl_d = sysctl_q;
        if (state_q == ST_HW_HW_STANDBY_PIN)
            sysctl_d = SYSCTL_RST;
        else if (ctl_wr)
            sysctl_d = (i_pwdata[7:0] & SYSCTL_WMASK) | (sysctl_q & ~SYSCTL_WMASK);
    end
    // Mode state and counter; hardware never clears standby select on wake
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_q <= ST_CLEAR;
            settle_q <= '0;
            sysctl_q <= SYSCTL_RST;
        end
        else
        begin
            state_q <= state_d;
            settle_q <= settle_d;
            sysctl_q <= sysctl_d;
        end
    end
    // Mask latch at SLEEP and wake source tracking
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            nmi_prev_q <= 1'b1;
            mask_at_sleep_q <= 1'b0;
            wake_src_ext_q <= 1'b0;
        end
        else
        begin
            nmi_prev_q <= nmi_lvl;
            if (state_q == ST_RUN && i_sleep_exec)
                mask_at_sleep_q <= i_int_mask;
            if (state_q == ST_SW_HW_STANDBY_PIN && state_d == ST_SETTLE)
                wake_src_ext_q <= 1'b1;
            else if (state_d == ST_CLEAR)
                wake_src_ext_q <= 1'b0;
        end
    end
    // Registered outputs
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_ctl <= CTL_RST;
            o_wake_int <= 1'b0;
            o_reset_exc <= 1'b0;
            o_onchip_ram_enable <= SYSCTL_RST[RAM_EN_BIT];
            o_nmi_edge_select <= SYSCTL_RST[NMI_EDGE_BIT];
        end
        else
        begin
            o_ctl <= ctl_d;
            o_wake_int <= wake_int_d;
            o_reset_exc <= reset_exc_d;
            o_onchip_ram_enable <= sysctl_d[RAM_EN_BIT];
            o_nmi_edge_select <= sysctl_d[NMI_EDGE_BIT];
        end
    end
    // APB answer; pready rises for exactly the first access cycle
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0;
        end
        else
        begin
            o_pready <= apb_setup;
            o_pslverr <= apb_setup && (!(hit_ctl || hit_stat) || wr_to_stat);
            if (apb_setup)
                o_prdata <= i_pwrite ? 32'h0 : rd_mux;
        end
    end
endmodule

// [verif/pd_ctrl_monitor.sv]
`timescale 1ns/1ps
module pd_ctrl_monitor
    import pd_ctrl_pkg::*;
(
    // Clock, reset and bus handshake
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // Mode inputs and outputs
    input wire logic i_sleep_exec,
    input wire logic i_int_mask,
    input wire logic i_nmi_n,
    input wire logic i_chip_clear_pin_n,
    input wire logic i_hw_standby_pin_n,
    input wire pd_ctl_s o_ctl,
    input wire logic o_wake_int,
    input wire logic o_reset_exc
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    // Running with both pins idle, so SLEEP or software standby must be taken
    sequence sleep_go;
        i_sleep_exec && !o_ctl.cpu_halt && i_hw_standby_pin_n && i_chip_clear_pin_n;
    endsequence
    // Six samples cover the pin synchroniser and the state update
    sequence clr_held;
        (!i_chip_clear_pin_n && i_hw_standby_pin_n) [*6];
    endsequence
    sequence hws_held;
        (!i_hw_standby_pin_n) [*6];
    endsequence

    AST_APB_ZERO_WAIT: assert property (i_psel && !i_penable |=> o_pready)
        else $error("pready missing in first access cycle");
    AST_APB_ONE_CYCLE: assert property (o_pready |=> !o_pready)
        else $error("pready stood longer than one cycle");
    AST_APB_ERR_QUAL: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    AST_SLEEP_ENTRY: assert property (sleep_go |-> ##[1:3] o_ctl.cpu_halt)
        else $error("SLEEP did not halt the cpu");
    AST_SLEEP_PERIPH: assert property (o_ctl.cpu_halt && o_ctl.periph_clk_en |->
        o_ctl.sys_clk_en && !o_ctl.periph_reset && !o_ctl.cpu_reg_reset)
        else $error("sleep disturbed peripherals or cpu registers");
    AST_MASKED_SLEEP: assert property ((i_nmi_n && i_int_mask && o_ctl.periph_clk_en
        && o_ctl.cpu_halt) [*5] |-> !o_wake_int)
        else $error("masked sleep woke without nmi");
    AST_HW_STANDBY_PIN_HOLD: assert property (o_ctl.port_hold |->
        !o_ctl.sys_clk_en && !o_ctl.port_hiz && !o_ctl.cpu_reg_reset)
        else $error("port hold with clock running or registers lost");
    AST_CLEAR_RESET: assert property (clr_held |-> o_ctl.chip_reset && o_ctl.osc_en)
        else $error("clear pin low without reset and oscillator");
    AST_HWS_FORCE: assert property (hws_held |-> o_ctl.port_hiz && o_ctl.cpu_reg_reset
        && !o_reset_exc && !o_wake_int)
        else $error("hw standby pin low not obeyed");
endmodule

bind power_down_mode_controller pd_ctrl_monitor i_mon (.i_clk, .i_arst_n, .i_psel,
    .i_penable, .o_pready, .o_pslverr, .i_sleep_exec, .i_int_mask, .i_nmi_n,
    .i_chip_clear_pin_n, .i_hw_standby_pin_n, .o_ctl, .o_wake_int, .o_reset_exc);

// [verif/pd_pin_model.sv]
`timescale 1ns/1ps
module pd_pin_model (
    // Clock
    input wire logic i_clk,
    // Cpu side and pins toward the controller
    output logic o_sleep_exec,
    output logic o_int_mask,
    output logic [7:0] o_ext_en,
    output logic [27:0] o_pin_q
);
    // Pins idle high; bit 27 is the accepted interrupt request
    // Boot mode pins stay steady and never both low, so they are left out
    initial
    begin
        o_sleep_exec = 1'b0;
        o_int_mask = 1'b0;
        o_ext_en = 8'hFF;
        o_pin_q = 28'h7FFFFFF;
    end
    // Standby entry drops enables that cannot wake from standby
    task automatic sleep(input logic mask, input logic hw_standby_pin);
        @(posedge i_clk);
        if (hw_standby_pin)
            o_ext_en <= 8'h47;
        o_int_mask <= mask;
        o_sleep_exec <= 1'b1;
        @(posedge i_clk);
        o_sleep_exec <= 1'b0;
    endtask
    task automatic set_pin(input int idx, input logic v);
        @(posedge i_clk);
        o_pin_q[idx] <= v;
    endtask
    // Clear held low long enough for the oscillator to settle
    task automatic clear_pulse(input int n);
        @(posedge i_clk);
        o_pin_q[1] <= 1'b0;
        repeat (n) @(posedge i_clk);
        o_pin_q[1] <= 1'b1;
    endtask
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top
    import pd_ctrl_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, o_prdata, q, w;
    logic o_pready, o_pslverr, o_wake_int, o_reset_exc, e, sx, im, ram_en, nes;
    logic [7:0] en;
    logic [27:0] p;
    pd_ctl_s o_ctl;
    int error_cnt = 0, check_count = 0, cyc = 0, n;
    int len[6] = '{16, 20, 24, 28, 32, 1024};
    int src[6] = '{PIN_EXT, PIN_EXT + 1, PIN_EXT + 2, PIN_EXT + 6, PIN_KEY, PIN_NMI};

    // 200 MHz clock
    always #2.5 i_clk = ~i_clk;

    // Short settling lengths keep the run brief
    power_down_mode_controller #(.SETTLE_8K_STATES(18'h00010), .SETTLE_16K_STATES(18'h00014),
        .SETTLE_32K_STATES(18'h00018), .SETTLE_64K_STATES(18'h0001C),
        .SETTLE_128K_STATES(18'h00020)) i_power_down_mode_controller (.i_clk, .i_arst_n,
        .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
        .o_pslverr, .i_sleep_exec(sx), .i_int_mask(im), .i_int_req(p[27]),
        .i_ext_int_enable_bits(en), .i_nmi_n(p[PIN_NMI]), .i_chip_clear_pin_n(p[PIN_CLR]),
        .i_hw_standby_pin_n(p[PIN_HWS]), .i_ext_int_pins_n(p[10:3]),
        .i_key_wake_inputs_n(p[26:11]), .o_ctl, .o_wake_int, .o_reset_exc,
        .o_onchip_ram_enable(ram_en), .o_nmi_edge_select(nes));
    pd_pin_model i_pins (.i_clk, .o_sleep_exec(sx), .o_int_mask(im), .o_ext_en(en),
        .o_pin_q(p));

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; waits for pready with no assumed latency
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        q = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic st(input logic [2:0] s);
        apb(1'b0, PDSTAT_OFS, 32'h0);
        check(q[2:0], s);
    endtask
    task automatic wait_pulse(input logic rst);
        n = 0;
        while ((rst ? o_reset_exc : o_wake_int) !== 1'b1 && n < 3000)
        begin
            @(posedge i_clk);
            n++;
        end
        check(n < 3000, 1'b1);
    endtask

    // Hang guard
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            final_report();
        end
    end

    initial
    begin
        repeat (8) @(posedge i_clk);
        i_arst_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        apb(1'b0, SYSCTL_OFS, 32'h0);
        check(q, 32'h09);
        apb(1'b1, SYSCTL_OFS, 32'h0);
        apb(1'b0, SYSCTL_OFS, 32'h0);
        check(q, 32'h08);
        apb(1'b1, 12'h008, 32'hFF);
        check(e, 1'b1);
        check(q, 32'h0);
        apb(1'b1, PDSTAT_OFS, 32'h0);
        check(e, 1'b1);
        apb(1'b1, SYSCTL_OFS, 32'h01);
        $display("Test registers done");
        // Sleep, then an accepted interrupt
        i_pins.sleep(1'b0, 1'b0);
        st(3'h1);
        check(o_ctl.periph_clk_en, 1'b1);
        i_pins.set_pin(27, 1'b1);
        wait_pulse(1'b0);
        i_pins.set_pin(27, 1'b0);
        // Masked sleep ignores requests, falling nmi wakes
        i_pins.sleep(1'b1, 1'b0);
        i_pins.set_pin(27, 1'b1);
        repeat (20) @(posedge i_clk);
        st(3'h1);
        i_pins.set_pin(PIN_NMI, 1'b0);
        wait_pulse(1'b0);
        i_pins.set_pin(PIN_NMI, 1'b1);
        i_pins.set_pin(27, 1'b0);
        // Clear pin during sleep
        i_pins.sleep(1'b0, 1'b0);
        fork
            i_pins.clear_pulse(20);
            begin
                repeat (8) @(posedge i_clk);
                st(3'h4);
            end
        join
        wait_pulse(1'b1);
        $display("Test sleep done");
        // Software standby for every settling code and wake source
        // Bench clock counts as external, so every code is legal, not only 8 ms ones
        for (int c = 0; c < 6; c++)
        begin
            w = 32'h81 | (c << 4) | ((c == 5) ? 32'h04 : 32'h0);
            apb(1'b1, SYSCTL_OFS, w);
            i_pins.sleep(1'b0, 1'b1);
            check(nes, c == 5);
            st(3'h2);
            check({o_ctl.sys_clk_en, o_ctl.periph_reset, o_ctl.port_hold}, 3'h3);
            i_pins.set_pin((c == 5) ? PIN_NMI : PIN_EXT + 3, 1'b0);
            repeat (10) @(posedge i_clk);
            st(3'h2);
            i_pins.set_pin(src[c], c == 5);
            n = 0;
            while (o_wake_int !== 1'b1 && n < 3000)
            begin
                @(posedge i_clk);
                if (o_ctl.osc_en === 1'b1 && o_ctl.sys_clk_en === 1'b0)
                    n++;
            end
            check(n, len[c]);
            i_pins.set_pin(src[c], 1'b1);
            i_pins.set_pin(PIN_EXT + 3, 1'b1);
            apb(1'b0, SYSCTL_OFS, 32'h0);
            check(q, w | 32'h08);
            apb(1'b1, SYSCTL_OFS, 32'h01);
        end
        // Clear pin in software standby
        apb(1'b1, SYSCTL_OFS, 32'h81);
        i_pins.sleep(1'b0, 1'b1);
        fork
            i_pins.clear_pulse(30);
            begin
                repeat (8) @(posedge i_clk);
                check(o_ctl.osc_en, 1'b1);
            end
        join
        wait_pulse(1'b1);
        $display("Test software standby done");
        // Hardware standby wins over clear, left through clear
        apb(1'b1, SYSCTL_OFS, 32'h80);
        i_pins.set_pin(PIN_CLR, 1'b0);
        check(ram_en, 1'b0);
        i_pins.set_pin(PIN_HWS, 1'b0);
        repeat (6) @(posedge i_clk);
        check({o_ctl.port_hiz, o_ctl.cpu_reg_reset, o_ctl.periph_clk_en}, 3'h6);
        i_pins.set_pin(PIN_HWS, 1'b1);
        repeat (6) @(posedge i_clk);
        check({o_ctl.chip_reset, o_reset_exc}, 2'h2);
        i_pins.set_pin(PIN_CLR, 1'b1);
        wait_pulse(1'b1);
        apb(1'b0, SYSCTL_OFS, 32'h0);
        check(q, 32'h09);
        check(ram_en, 1'b1);
        $display("Test hardware standby done");
        final_report();
    end
endmodule
